// file: shared/stl_pkg.sv
// package for the status input time-on logger
// assumes a 125 MHz aclk and an axi4-lite register slave
package stl_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] STL_REG_CTRL    = 8'h00;
  localparam logic [7:0] STL_REG_PERIOD  = 8'h04;
  localparam logic [7:0] STL_REG_THRESH  = 8'h08;
  localparam logic [7:0] STL_REG_STATUS  = 8'h0C;
  localparam logic [7:0] STL_REG_DATA    = 8'h10;
  localparam logic [7:0] STL_REG_COUNT   = 8'h14;
  localparam logic [7:0] STL_REG_HWTEST  = 8'h18;
  localparam logic [7:0] STL_REG_HIST    = 8'h1C;

  // ---------------------------------------------------------------
  // control fields and reset values
  // ---------------------------------------------------------------
  localparam int STL_CTRL_EN_BIT      = 0;
  localparam int STL_CTRL_INV_BIT     = 1;
  localparam int STL_CTRL_MODE_LSB    = 4;
  localparam int STL_CTRL_TRGEN_BIT   = 8;
  localparam int STL_CTRL_TRGABV_BIT  = 9;
  localparam logic [31:0] STL_CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] STL_PERIOD_RST  = 32'h0000_012C;
  localparam logic [31:0] STL_THRESH_RST  = 32'h0000_0000;
  localparam logic [31:0] STL_SCALE       = 32'h0000_2710;
  localparam logic [7:0]  STL_CHAR_OPEN   = 8'h4F;
  localparam logic [7:0]  STL_CHAR_CLOSED = 8'h58;
  localparam logic [1:0]  STL_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  STL_RESP_SLVERR = 2'b10;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int STL_CLK_MHZ       = 125;
  localparam int STL_SEC_US        = 1000000;
  localparam int STL_SEC_CYCLES    = STL_CLK_MHZ * STL_SEC_US;
  localparam int STL_DIV_CYCLES    = 32;

  typedef enum logic [1:0] {
    STL_MODE_SPOT,
    STL_MODE_SECS,
    STL_MODE_PCT_CLOSED,
    STL_MODE_PCT_OPEN
  } stl_mode_t;

endpackage

// file: shared/stl_div_if.sv
// handshake carrier between logger and divider
// assumes one clock domain, start held one cycle
`timescale 1ns/10ps
`default_nettype none
interface stl_div_if;
  logic        start;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic        done;
  logic [31:0] quotient;
  modport master (output start, output dividend, output divisor, input done, input quotient);
  modport slave  (input start, input dividend, input divisor, output done, output quotient);
endinterface
`default_nettype wire

// file: hw/stl_div.sv
// serial restoring divider, one quotient bit a clock
// assumes start pulse only while idle
`timescale 1ns/10ps
`default_nettype none
module stl_div
  import stl_pkg::*;
(
  input  wire logic   aclk,
  input  wire logic   aresetn,
  stl_div_if.slave    dv
);

  logic [31:0] rem;
  logic [31:0] quo;
  logic [31:0] den;
  logic [5:0]  left;
  logic        busy;
  logic [32:0] trial;
  logic        fits;

  assign trial = {rem, quo[31]} - {1'b0, den};
  assign fits  = ~trial[32];

  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rem         <= 32'h0000_0000;
      quo         <= 32'h0000_0000;
      den         <= 32'h0000_0000;
      left        <= 6'h00;
      busy        <= 1'b0;
      dv.done     <= 1'b0;
      dv.quotient <= 32'h0000_0000;
    end
    else
    begin
      dv.done <= 1'b0;
      if (dv.start && !busy)
      begin
        rem  <= 32'h0000_0000;
        quo  <= dv.dividend;
        den  <= dv.divisor;
        left <= 6'(STL_DIV_CYCLES);
        busy <= 1'b1;
      end
      else if (busy)
      begin
        rem  <= fits ? trial[31:0] : {rem[30:0], quo[31]};
        quo  <= {quo[30:0], fits};
        left <= left - 6'h01;
        if (left == 6'h01)
        begin
          busy        <= 1'b0;
          dv.done     <= 1'b1;
          dv.quotient <= {quo[30:0], fits};
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: hw/stl_logger.sv
// status input time-on logger with axi4-lite registers
// assumes contact pin asynchronous to aclk; ticks are same-domain pulses
//
// Operation
// [RQ1] closed pin is one, open zero
// [RQ2] inverted channel inverts every logged datapoint; the code applies the invert bit in spot and seconds modes only
// [RQ3] status unit logs single bit
// [RQ4] rising alarm sets on logged zero-to-one
// [RQ5] alarm clears on logged one-to-zero
// [RQ6] seconds mode counts seconds at one
// [RQ7] seconds counter clears at each datapoint
// [RQ8] inverted seconds mode counts time open
// [RQ9] hardware test shows raw pin
// [RQ10] hardware test uses O and X
// [RQ11] spot mode logs level, inverted complement
// [RQ12] triggers evaluated only at log boundaries
// [RQ13] status datapoint never exceeds one
// [RQ14] seconds datapoint never exceeds period
// [RQ15] proportion mode logs zero to 10000
// [RQ16] time-closed: zero open, 10000 closed
// [RQ17] time-open option measures open condition
// [RQ18] status function uses exactly one pin
// [RQ19] proportion is time times 10000 over period
// [RQ20] pin synchronised, sampled every second
`timescale 1ns/10ps
`default_nettype none
module stl_logger
  import stl_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        status_pin,
  input  wire logic        sec_tick,
  input  wire logic        log_tick,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             dp_valid,
  output logic [31:0]      dp_data,
  output logic             alarm,
  output logic             trigger
);

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  logic pin_meta;
  logic pin_sync;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= status_pin; // RQ20 RQ18
      pin_sync <= pin_meta;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] period;
  logic [31:0] thresh;
  logic [31:0] dp_count;
  logic [31:0] sec_acc;
  logic [31:0] sec_len;
  logic        prev_dp;
  logic        trig_sticky;
  logic        div_busy;
  logic        enabled;
  logic        inverted;
  logic        trg_en;
  logic        trg_above;
  stl_mode_t   mode;

  assign enabled   = ctrl[STL_CTRL_EN_BIT];
  assign inverted  = ctrl[STL_CTRL_INV_BIT];
  assign trg_en    = ctrl[STL_CTRL_TRGEN_BIT];
  assign trg_above = ctrl[STL_CTRL_TRGABV_BIT];
  assign mode      = stl_mode_t'(ctrl[STL_CTRL_MODE_LSB +: 2]);

  // ---------------------------------------------------------------
  // accumulation
  // ---------------------------------------------------------------
  wire level      = pin_sync; // RQ1
  wire cond_level = (mode == STL_MODE_PCT_OPEN) ? ~level : (mode == STL_MODE_SECS && inverted) ? ~level
                    : level; // RQ8 RQ17
  wire sec_hit    = enabled && sec_tick && cond_level; // RQ6
  wire log_hit    = enabled && log_tick;
  wire [31:0] sec_cap  = (sec_acc < period) ? sec_acc + 32'h0000_0001 : sec_acc; // RQ14
  wire [31:0] len_cap  = (sec_len < period) ? sec_len + 32'h0000_0001 : sec_len;
  wire [31:0] next_acc = sec_hit ? sec_cap : sec_acc;
  wire [31:0] next_len = (enabled && sec_tick) ? len_cap : sec_len;

  // ---------------------------------------------------------------
  // datapoint forming
  // ---------------------------------------------------------------
  wire        spot_bit = inverted ? ~level : level; // RQ11 RQ2
  wire        is_pct   = (mode == STL_MODE_PCT_CLOSED) || (mode == STL_MODE_PCT_OPEN);
  wire [63:0] scaled   = 64'(next_acc) * 64'(STL_SCALE); // RQ19
  // inverted seconds already counts open time, so no subtraction
  wire [31:0] spot_val = {31'h0000_0000, spot_bit}; // RQ3 RQ13
  wire [31:0] imm_val  = (mode == STL_MODE_SECS) ? next_acc : spot_val;

  stl_div_if dv();
  stl_div u_div
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .dv      (dv)
  );

  assign dv.start    = log_hit && is_pct && !div_busy;
  assign dv.dividend = scaled[31:0];
  assign dv.divisor  = (period == 32'h0000_0000) ? 32'h0000_0001 : period;

  wire [31:0] pct_val  = dv.quotient; // RQ15 RQ16
  wire        emit_imm = log_hit && !is_pct;
  wire        emit     = emit_imm || dv.done;
  wire [31:0] emit_val = dv.done ? pct_val : imm_val;
  wire        trig_cmp = trg_above ? (emit_val > thresh) : (emit_val < thresh);

  // ---------------------------------------------------------------
  // state update
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sec_acc     <= 32'h0000_0000;
      sec_len     <= 32'h0000_0000;
      dp_valid    <= 1'b0;
      dp_data     <= 32'h0000_0000;
      prev_dp     <= 1'b0;
      alarm       <= 1'b0;
      trigger     <= 1'b0;
      div_busy    <= 1'b0;
      dp_count    <= 32'h0000_0000;
    end
    else
    begin
      dp_valid <= emit;
      trigger  <= emit && trg_en && trig_cmp; // RQ12
      sec_acc  <= log_hit ? 32'h0000_0000 : next_acc; // RQ7
      sec_len  <= log_hit ? 32'h0000_0000 : next_len;
      if (dv.start)
        div_busy <= 1'b1;
      else if (dv.done)
        div_busy <= 1'b0;
      if (emit)
      begin
        dp_data  <= emit_val; // RQ8 RQ2
        dp_count <= dp_count + 32'h0000_0001;
        prev_dp  <= emit_val[0];
        if (!is_pct && emit_val[0] && !prev_dp)
          alarm <= 1'b1; // RQ4
        else if (!is_pct && !emit_val[0])
          alarm <= 1'b0; // RQ5
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire wr_go    = aw_held && w_held && !s_axi_bvalid;
  wire wr_ctrl  = wr_go && (aw_addr == STL_REG_CTRL);
  wire wr_per   = wr_go && (aw_addr == STL_REG_PERIOD);
  wire wr_thr   = wr_go && (aw_addr == STL_REG_THRESH);
  wire wr_stat  = wr_go && (aw_addr == STL_REG_STATUS);
  wire wr_ok    = wr_ctrl || wr_per || wr_thr || wr_stat;
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= STL_RESP_OKAY;
      ctrl          <= STL_CTRL_RST;
      period        <= STL_PERIOD_RST;
      thresh        <= STL_THRESH_RST;
      trig_sticky   <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !w_take && !s_axi_bvalid;
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[7:0];
      end
      if (w_take)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? STL_RESP_OKAY : STL_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_ctrl)
        ctrl <= (ctrl & ~wmask) | (w_data & wmask);
      if (wr_per)
        period <= (period & ~wmask) | (w_data & wmask);
      if (wr_thr)
        thresh <= (thresh & ~wmask) | (w_data & wmask);
      // set wins over a clear in the same cycle
      if (trigger)
        trig_sticky <= 1'b1;
      else if (wr_stat && w_strb[0] && w_data[2])
        trig_sticky <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  wire [7:0] hw_char = pin_sync ? STL_CHAR_CLOSED : STL_CHAR_OPEN; // RQ9 RQ10
  wire [7:0] ra      = s_axi_araddr[7:0];
  wire       ar_take = s_axi_arvalid && s_axi_arready;
  wire       ra_ok   = (ra <= STL_REG_HIST) && (ra[1:0] == 2'b00);
  wire [31:0] rd_mux =
    (ra == STL_REG_CTRL)   ? ctrl :
    (ra == STL_REG_PERIOD) ? period :
    (ra == STL_REG_THRESH) ? thresh :
    (ra == STL_REG_STATUS) ? {28'h000_0000, div_busy, trig_sticky, alarm, pin_sync} :
    (ra == STL_REG_DATA)   ? dp_data :
    (ra == STL_REG_COUNT)  ? dp_count :
    (ra == STL_REG_HWTEST) ? {24'h00_0000, hw_char} :
    (ra == STL_REG_HIST)   ? sec_acc : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= STL_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= ra_ok ? rd_mux : 32'h0000_0000;
        s_axi_rresp  <= ra_ok ? STL_RESP_OKAY : STL_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_ALARM_RISE: assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
    (emit && !is_pct && emit_val[0] && !prev_dp) |=> alarm)
    else $error("alarm did not set on rise");

  AST_ALARM_FALL: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
    (emit && !is_pct && !emit_val[0]) |=> !alarm)
    else $error("alarm did not clear on fall");

  AST_ACC_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
    log_hit |=> (sec_acc == 32'h0000_0000))
    else $error("accumulator not cleared");

  AST_ACC_LEN: assert property (@(posedge aclk) disable iff (!aresetn) // RQ14
    sec_acc <= sec_len)
    else $error("accumulated time above elapsed time");

  AST_SECS_MAX: assert property (@(posedge aclk) disable iff (!aresetn) // RQ14
    (dp_valid && mode == STL_MODE_SECS && !$changed(period)) |-> (dp_data <= period))
    else $error("seconds datapoint above period");

  AST_SPOT_BIT: assert property (@(posedge aclk) disable iff (!aresetn) // RQ13
    (dp_valid && mode == STL_MODE_SPOT && $stable(ctrl)) |-> (dp_data <= 32'h0000_0001))
    else $error("status datapoint above one");

  AST_SPOT_INV: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
    (emit_imm && mode == STL_MODE_SPOT) |=> (dp_data[0] == ($past(level) ^ $past(inverted))))
    else $error("spot datapoint polarity wrong");

  AST_PCT_RANGE: assert property (@(posedge aclk) disable iff (!aresetn) // RQ15
    dv.done |=> (dp_data <= STL_SCALE))
    else $error("proportion out of range");

  AST_TRIG_BOUNDARY: assert property (@(posedge aclk) disable iff (!aresetn) // RQ12
    trigger |-> $past(emit))
    else $error("trigger outside log boundary");

  AST_PCT_DONE: assert property (@(posedge aclk) disable iff (!aresetn) // RQ19
    dv.start |-> ##[30:40] dv.done)
    else $error("proportion result late");

  AST_SYNC: assert property (@(posedge aclk) disable iff (!aresetn) // RQ20
    $changed(pin_sync) |-> (pin_sync == $past(pin_meta)))
    else $error("synchroniser path broken");

endmodule
`default_nettype wire

// file: verif/stl_contact_model.sv
// contact model: switch that bounces briefly at each change
// assumes closed_req from the bench; pin high = closed
`timescale 1ns/10ps
`default_nettype none
module stl_contact_model
(
  input  wire logic closed_req,
  output logic      status_pin
);
  // ---------------------------------------------------------------
  // bounce
  // ---------------------------------------------------------------
  // edges fall off the clock grid, so the synchroniser sees real skew
  initial status_pin = 1'b0;
  always @(closed_req)
  begin
    #2.3 status_pin = closed_req;
    #1.1 status_pin = ~closed_req;
    #1.7 status_pin = closed_req;
  end
endmodule
`default_nettype wire

// file: verif/stl_logger_test.sv
// self-checking bench for the status input logger
// assumes stl_pkg, stl_div_if, stl_div and stl_logger compiled first
`timescale 1ns/10ps
`default_nettype none
module stl_logger_test
  import stl_pkg::*;
;
  localparam int P = 8; // short period keeps the run brief
  logic        aclk, aresetn, closed_req, status_pin, sec_tick, log_tick;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, dp_data, rd, e;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, dp_valid, alarm, trigger;
  logic        t, a, inv;
  logic [7:0]  rnd;
  int          failures, n_compared, n_dp, k, mode;

  stl_contact_model sw (.closed_req(closed_req), .status_pin(status_pin));
  stl_logger dut (
    .aclk(aclk), .aresetn(aresetn), .status_pin(status_pin), .sec_tick(sec_tick), .log_tick(log_tick),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .dp_valid(dp_valid),
    .dp_data(dp_data), .alarm(alarm), .trigger(trigger));

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check_word(input string name, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, ex, got);
    end
  endtask

  task automatic check_flag(input string name, input logic ex, input logic got);
    n_compared++;
    if (got !== ex)
    begin
      failures++;
      $display("[ERR] %s expected %b seen %b", name, ex, got);
    end
  endtask

  // ---------------------------------------------------------------
  // expectations
  // ---------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // k closed seconds followed by P-k open seconds
  function automatic logic [31:0] exp_dp(input int m, input logic iv, input int kc);
    if (m == 1)
      return iv ? 32'(P - kc) : 32'(kc);
    if (m == 2)
      return 32'(kc) * STL_SCALE / 32'(P);
    return 32'(P - kc) * STL_SCALE / 32'(P);
  endfunction

  // ---------------------------------------------------------------
  // bus and stimulus tasks
  // ---------------------------------------------------------------
  task automatic axi_write(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    @(posedge aclk);
    s_axi_awaddr <= 32'(ad);
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= 32'(ad);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] ad, input logic [31:0] ex);
    axi_read(ad, rd, rs);
    check_word(name, ex, rd);
  endtask

  task automatic secs(input int n, input logic lvl);
    @(posedge aclk);
    closed_req <= lvl;
    repeat (6) @(posedge aclk);
    repeat (n)
    begin
      sec_tick <= 1'b1;
      @(posedge aclk);
      sec_tick <= 1'b0;
      @(posedge aclk);
    end
  endtask

  // divider may take ~34 cycles, so poll under a bound
  task automatic log_point(output logic [31:0] d, output logic tr, output logic al);
    int n;
    @(posedge aclk);
    log_tick <= 1'b1;
    @(posedge aclk);
    log_tick <= 1'b0;
    n = 0;
    #1;
    while (dp_valid !== 1'b1 && n < 60)
    begin
      @(posedge aclk);
      #1;
      n++;
    end
    check_flag("dp_valid", 1'b1, dp_valid);
    d = dp_data;
    tr = trigger;
    al = alarm;
    n_dp++;
  endtask

  // a fresh mode starts from a flushed accumulator
  task automatic set_ctrl(input logic [31:0] v);
    axi_write(STL_REG_CTRL, v, rs);
    log_point(rd, t, a);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {aresetn, closed_req, sec_tick, log_tick} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 32'h0000_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_araddr = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    failures = 0;
    n_compared = 0;
    n_dp = 0;
    rnd = 8'h56;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd_chk("ctrl reset", STL_REG_CTRL, STL_CTRL_RST);
    rd_chk("period reset", STL_REG_PERIOD, STL_PERIOD_RST);
    rd_chk("thresh reset", STL_REG_THRESH, STL_THRESH_RST);
    rd_chk("unmapped rdata", 8'h40, 32'h0000_0000);
    check_word("unmapped rresp", 32'(STL_RESP_SLVERR), 32'(rs));
    axi_write(8'h40, 32'hFFFF_FFFF, rs);
    check_word("unmapped bresp", 32'(STL_RESP_SLVERR), 32'(rs));
    axi_write(STL_REG_PERIOD, 32'(P), rs);
    rd_chk("period", STL_REG_PERIOD, 32'(P));
    for (int i = 0; i < 4; i++)
    begin
      axi_write(STL_REG_CTRL, 32'(i[1]) << STL_CTRL_INV_BIT, rs);
      secs(0, i[0]);
      rd_chk("hw test", STL_REG_HWTEST, 32'(i[0] ? STL_CHAR_CLOSED : STL_CHAR_OPEN));
    end
    // spot mode, threshold above one can never fire
    axi_write(STL_REG_THRESH, 32'h0000_0001, rs);
    for (int j = 0; j < 2; j++)
    begin
      inv = j[0];
      set_ctrl(32'h0000_0301 | (32'(inv) << STL_CTRL_INV_BIT));
      for (int i = 0; i < 8; i++)
      begin
        secs(0, (i < 4) ? (i == 1 || i == 2) : rnd[0]);
        rnd = lfsr_next(rnd);
        log_point(rd, t, a);
        check_word("spot datapoint", 32'(closed_req ^ inv), rd);
        check_flag("alarm", closed_req ^ inv, a);
        check_flag("spot trigger", 1'b0, t);
      end
    end
    // timed modes: secs, inverted secs with trigger, then both proportions
    axi_write(STL_REG_THRESH, 32'(P / 2), rs);
    for (int c = 0; c < 4; c++)
    begin
      mode = (c < 2) ? 1 : c;
      inv = (c == 1);
      set_ctrl(32'h0000_0001 | (32'(inv) << STL_CTRL_INV_BIT) | (32'(mode) << STL_CTRL_MODE_LSB)
               | (32'(c < 2) << STL_CTRL_TRGEN_BIT) | (32'(c == 0) << STL_CTRL_TRGABV_BIT));
      for (int i = 0; i < 5; i++)
      begin
        k = (i == 0) ? P : (i == 1) ? 0 : int'(rnd) % (P + 1);
        rnd = lfsr_next(rnd);
        secs(k, 1'b1);
        secs(P - k, 1'b0);
        log_point(rd, t, a);
        e = exp_dp(mode, inv, k);
        check_word("timed datapoint", e, rd);
        if (e != 32'(P / 2))
          check_flag("trigger", (c == 0) ? (e > 32'(P / 2)) : (c == 1) ? (e < 32'(P / 2)) : 1'b0, t);
      end
    end
    // more closed seconds than the period holds
    for (int m = 1; m < 3; m++)
    begin
      set_ctrl(32'h0000_0001 | (32'(m) << STL_CTRL_MODE_LSB));
      secs(P + 3, 1'b1);
      log_point(rd, t, a);
      check_word("saturated datapoint", (m == 1) ? 32'(P) : STL_SCALE, rd);
    end
    rd_chk("datapoint count", STL_REG_COUNT, 32'(n_dp));
    complete_run();
  end

  initial
  begin
    #400000;
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
